// file: design/mcbl_pkg.sv
`default_nettype none
package mcbl_pkg;
   // Configuration image
   localparam int unsigned IMAGE_BYTES = 22;
   localparam int unsigned CU_BYTES = 8;
   localparam logic [4:0] LAST_INDEX = 5'h15;
   localparam logic [4:0] FIRST_FWD_INDEX = 5'h08;
   localparam logic [5:0] MAX_COUNT = 6'h16;

   // Byte zero and byte one fields
   localparam int unsigned COUNT_MSB = 5;
   localparam int unsigned TX_THR_MSB = 6;
   localparam int unsigned TX_THR_LSB = 4;
   localparam int unsigned RX_THR_MSB = 3;
   localparam int unsigned RX_THR_LSB = 0;
   localparam logic [7:0] BYTE0_KEEP = 8'h3f;
   localparam logic [7:0] BYTE1_KEEP = 8'h7f;

   // Reset image of the command unit bytes
   localparam logic [7:0] BYTE0_RESET = 8'h00;
   localparam logic [7:0] BYTE1_RESET = 8'h08;
   localparam logic [7:0] BYTEN_RESET = 8'h00;

   // Threshold arithmetic, in Dwords
   localparam logic [5:0] RX_SHALLOW_BASE = 6'h10;
   localparam logic [5:0] RX_DEEP_BASE = 6'h20;

   // Register port map
   localparam logic [3:0] REG_CU_BYTE0 = 4'h0;
   localparam logic [3:0] REG_CU_BYTE7 = 4'h7;
   localparam logic [3:0] REG_CONTROL = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'h9;
   localparam int unsigned CTRL_DEEP_BIT = 0;
   localparam int unsigned STAT_BUSY_BIT = 7;
   localparam logic CTRL_DEEP_RESET = 1'b0;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_LOAD,
      ST_DRAIN
   } mcbl_state_t;
endpackage : mcbl_pkg
`default_nettype wire

// file: design/mcbl_loader.sv
`default_nettype none
module mcbl_loader (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic loadStart,
   input wire logic inValid,
   input wire logic [7:0] inData,
   output logic inReady,
   output logic fwdValid,
   output logic [7:0] fwdData,
   output logic [4:0] fwdIndex,
   input wire logic fwdReady,
   output logic busy,
   output logic loadDone,
   output logic [63:0] cuConfig,
   output logic [2:0] txThrDwords,
   output logic [4:0] txThrBytes,
   output logic [5:0] rxThrDwords,
   output logic [7:0] rxThrBytes,
   input wire logic [3:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData
);
   mcbl_pkg::mcbl_state_t state, next_state;
   logic [4:0] idx, next_idx;
   logic [4:0] lastIdx, next_lastIdx;
   logic [7:0] cuMem [mcbl_pkg::CU_BYTES];
   logic [7:0] next_cuMem [mcbl_pkg::CU_BYTES];
   logic next_fwdValid;
   logic [7:0] next_fwdData;
   logic [4:0] next_fwdIndex;
   logic next_loadDone;
   logic rxDeep, next_rxDeep;
   logic [7:0] next_regRdData;
   logic take;
   logic fwdSlotFree;
   logic [5:0] cfgCount;
   logic [4:0] limIdx;
   logic [3:0] rxCode;
   logic [2:0] txCode;

   // Count decode for the first byte
   always_comb begin
      cfgCount = inData[mcbl_pkg::COUNT_MSB:0];
      if (cfgCount == 6'h00) begin
         limIdx = 5'h00;
      end else if (cfgCount > mcbl_pkg::MAX_COUNT) begin
         limIdx = mcbl_pkg::LAST_INDEX;
      end else begin
         limIdx = 5'(cfgCount - 6'h01);
      end
   end

   assign fwdSlotFree = !fwdValid || fwdReady;
   // Forwarded bytes stall on the transmit DMA side
   always_comb begin
      inReady = 1'b0;
      if (state == mcbl_pkg::ST_LOAD) begin
         if (idx < mcbl_pkg::FIRST_FWD_INDEX) begin
            inReady = 1'b1;
         end else begin
            inReady = fwdSlotFree;
         end
      end
   end
   assign take = inReady && inValid;

   always_comb begin
      next_state = state;
      next_idx = idx;
      next_lastIdx = lastIdx;
      next_cuMem = cuMem;
      next_fwdValid = fwdValid && !fwdReady;
      next_fwdData = fwdData;
      next_fwdIndex = fwdIndex;
      next_loadDone = 1'b0;
      unique case (state)
         mcbl_pkg::ST_IDLE: begin
            if (loadStart) begin
               next_state = mcbl_pkg::ST_LOAD;
               next_idx = 5'h00;
            end
         end
         mcbl_pkg::ST_LOAD: begin
            if (take) begin
               if (idx == 5'h00) begin
                  next_lastIdx = limIdx;
                  next_cuMem[0] = inData & mcbl_pkg::BYTE0_KEEP;
               end else if (idx == 5'h01) begin
                  next_cuMem[1] = inData & mcbl_pkg::BYTE1_KEEP;
               end else if (idx < mcbl_pkg::FIRST_FWD_INDEX) begin
                  next_cuMem[idx[2:0]] = inData;
               end else begin
                  next_fwdValid = 1'b1;
                  next_fwdData = inData;
                  next_fwdIndex = idx;
               end
               next_idx = idx + 5'h01;
               if ((idx == 5'h00 && limIdx == 5'h00) ||
                   (idx != 5'h00 && idx == lastIdx)) begin
                  if (idx < mcbl_pkg::FIRST_FWD_INDEX) begin
                     next_state = mcbl_pkg::ST_IDLE;
                     next_loadDone = 1'b1;
                  end else begin
                     next_state = mcbl_pkg::ST_DRAIN;
                  end
               end
            end
         end
         mcbl_pkg::ST_DRAIN: begin
            if (!next_fwdValid) begin
               next_state = mcbl_pkg::ST_IDLE;
               next_loadDone = 1'b1;
            end
         end
         default: begin
            next_state = mcbl_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state <= mcbl_pkg::ST_IDLE;
         idx <= 5'h00;
         lastIdx <= 5'h00;
         fwdValid <= 1'b0;
         fwdData <= 8'h00;
         fwdIndex <= 5'h00;
         loadDone <= 1'b0;
         cuMem[0] <= mcbl_pkg::BYTE0_RESET;
         cuMem[1] <= mcbl_pkg::BYTE1_RESET;
         for (int i = 2; i < mcbl_pkg::CU_BYTES; i++) begin
            cuMem[i] <= mcbl_pkg::BYTEN_RESET;
         end
      end else begin
         state <= next_state;
         idx <= next_idx;
         lastIdx <= next_lastIdx;
         fwdValid <= next_fwdValid;
         fwdData <= next_fwdData;
         fwdIndex <= next_fwdIndex;
         loadDone <= next_loadDone;
         cuMem <= next_cuMem;
      end
   end

   assign busy = (state != mcbl_pkg::ST_IDLE);
   assign cuConfig = {cuMem[7], cuMem[6], cuMem[5], cuMem[4],
                      cuMem[3], cuMem[2], cuMem[1], cuMem[0]};

   // Threshold decode from byte one
   assign txCode = cuMem[1][mcbl_pkg::TX_THR_MSB:mcbl_pkg::TX_THR_LSB];
   assign rxCode = cuMem[1][mcbl_pkg::RX_THR_MSB:mcbl_pkg::RX_THR_LSB];
   assign txThrDwords = txCode;
   assign txThrBytes = {txCode, 2'b00};
   always_comb begin
      if (rxDeep) begin
         rxThrDwords = mcbl_pkg::RX_DEEP_BASE - {1'b0, rxCode, 1'b0};
      end else begin
         rxThrDwords = mcbl_pkg::RX_SHALLOW_BASE - {2'b00, rxCode};
      end
   end
   assign rxThrBytes = {rxThrDwords, 2'b00};

   // Register port
   always_comb begin
      next_rxDeep = rxDeep;
      if (regWr && regAddr == mcbl_pkg::REG_CONTROL) begin
         next_rxDeep = regWrData[mcbl_pkg::CTRL_DEEP_BIT];
      end
      next_regRdData = 8'h00;
      if (regRd) begin
         if (regAddr <= mcbl_pkg::REG_CU_BYTE7) begin
            next_regRdData = cuMem[regAddr[2:0]];
         end else if (regAddr == mcbl_pkg::REG_CONTROL) begin
            next_regRdData[mcbl_pkg::CTRL_DEEP_BIT] = rxDeep;
         end else if (regAddr == mcbl_pkg::REG_STATUS) begin
            next_regRdData[mcbl_pkg::STAT_BUSY_BIT] = busy;
            next_regRdData[4:0] = idx;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rxDeep <= mcbl_pkg::CTRL_DEEP_RESET;
         regRdData <= 8'h00;
      end else begin
         rxDeep <= next_rxDeep;
         regRdData <= next_regRdData;
      end
   end

   count_field_a: assert property (@(posedge sys_clk) disable iff (reset)
      take && idx == 5'h00 && state == mcbl_pkg::ST_LOAD &&
      inData[5:0] == 6'h08 |=> lastIdx == 5'h07)
      else $error("byte count not captured");
   short_load_a: assert property (@(posedge sys_clk) disable iff (reset)
      take && idx == 5'h00 && inData[5:0] <= 6'h01
      |=> loadDone && !busy)
      else $error("one-byte load did not finish");
   count_clamp_a: assert property (@(posedge sys_clk) disable iff (reset)
      busy && idx != 5'h00 |-> lastIdx <= mcbl_pkg::LAST_INDEX)
      else $error("load limit beyond last byte");
   fwd_only_tail_a: assert property (@(posedge sys_clk) disable iff (reset)
      $rose(fwdValid) |-> fwdIndex >= 5'h08 && fwdIndex <= 5'h15)
      else $error("bad forwarded byte index");
   fwd_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
      fwdValid && !fwdReady |=> fwdValid && $stable(fwdData)
      && $stable(fwdIndex))
      else $error("forwarded byte dropped");
   tx_units_a: assert property (@(posedge sys_clk) disable iff (reset)
      $changed(cuMem[1]) |-> txThrBytes == {cuMem[1][6:4], 2'b00}
      && txThrBytes <= 5'h1c)
      else $error("transmit threshold wrong");
   rx_shallow_a: assert property (@(posedge sys_clk) disable iff (reset)
      !rxDeep && take && idx == 5'h01
      |=> rxThrBytes == 8'h40 - {2'b00, $past(inData[3:0]), 2'b00})
      else $error("shallow receive threshold wrong");
   rx_deep_a: assert property (@(posedge sys_clk) disable iff (reset)
      rxDeep && !$changed(rxDeep) && rxCode == 4'h8
      |-> rxThrBytes == 8'h40)
      else $error("deep receive threshold wrong");
   reset_default_a: assert property (@(posedge sys_clk)
      $past(reset) && !reset |-> txThrBytes == 5'h00
      && rxThrBytes == 8'h20)
      else $error("threshold defaults wrong");
   fixed_bits_a: assert property (@(posedge sys_clk) disable iff (reset)
      cuMem[0][7:6] == 2'b00 && cuMem[1][7] == 1'b0)
      else $error("fixed bit position not zero");

   // Handshake, capture, load sequencing and threshold checks
   idle_no_ready_a: assert property (
      @(posedge sys_clk) disable iff (reset)
      !busy |-> !inReady)
      else $error("input ready while idle");

   cu_no_stall_a: assert property (
      @(posedge sys_clk) disable iff (reset)
      state == mcbl_pkg::ST_LOAD && idx < mcbl_pkg::FIRST_FWD_INDEX |-> inReady)
      else $error("command unit byte stalled");

   fwd_stall_a: assert property (
      @(posedge sys_clk) disable iff (reset)
      state == mcbl_pkg::ST_LOAD && idx >= mcbl_pkg::FIRST_FWD_INDEX &&
      fwdValid && !fwdReady |-> !inReady)
      else $error("input taken while forward slot full");

   fwd_capture_a: assert property (
      @(posedge sys_clk) disable iff (reset)
      take && idx >= mcbl_pkg::FIRST_FWD_INDEX |=> fwdValid &&
      fwdIndex == $past(idx) && fwdData == $past(inData))
      else $error("forwarded byte not captured");

   cu_capture_a: assert property (
      @(posedge sys_clk) disable iff (reset)
      take && idx >= 5'h02 && idx < mcbl_pkg::FIRST_FWD_INDEX
      |=> cuMem[$past(idx[2:0])] == $past(inData))
      else $error("command unit byte not stored");

   count_over_a: assert property (
      @(posedge sys_clk) disable iff (reset)
      take && idx == 5'h00 && inData[5:0] > mcbl_pkg::MAX_COUNT
      |=> lastIdx == mcbl_pkg::LAST_INDEX)
      else $error("oversized count not clamped");

   start_load_a: assert property (
      @(posedge sys_clk) disable iff (reset)
      !busy && loadStart |=> busy && idx == 5'h00)
      else $error("load did not start at byte zero");

   idle_hold_a: assert property (
      @(posedge sys_clk) disable iff (reset)
      !busy |=> $stable(cuConfig))
      else $error("configuration changed while idle");

   done_pulse_a: assert property (
      @(posedge sys_clk) disable iff (reset)
      loadDone |=> !loadDone)
      else $error("load done longer than one cycle");

   done_idle_a: assert property (
      @(posedge sys_clk) disable iff (reset)
      loadDone |-> !busy && !fwdValid)
      else $error("load done before forward drained");

   rx_shallow_range_a: assert property (
      @(posedge sys_clk) disable iff (reset)
      !rxDeep |-> rxThrBytes >= 8'h04 && rxThrBytes <= 8'h40)
      else $error("shallow receive threshold out of range");

   rx_deep_range_a: assert property (
      @(posedge sys_clk) disable iff (reset)
      rxDeep |-> rxThrBytes >= 8'h08 && rxThrBytes <= 8'h80)
      else $error("deep receive threshold out of range");

   rx_units_a: assert property (
      @(posedge sys_clk) disable iff (reset)
      rxThrBytes[1:0] == 2'b00 && rxThrBytes[7:2] == rxThrDwords)
      else $error("receive threshold not in Dwords");

   tx_dwords_a: assert property (
      @(posedge sys_clk) disable iff (reset)
      txThrBytes[1:0] == 2'b00 && txThrBytes[4:2] == txThrDwords)
      else $error("transmit threshold not in Dwords");
endmodule : mcbl_loader
`default_nettype wire

// file: verification/mcbl_host.sv
`default_nettype none
module mcbl_host (
   input wire logic sys_clk,
   input wire logic slow,
   input wire logic inReady,
   input wire logic fwdValid,
   input wire logic [7:0] fwdData,
   input wire logic [4:0] fwdIndex,
   output var logic loadStart,
   output var logic inValid,
   output var logic [7:0] inData,
   output var logic fwdReady
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] img [0:21];
   logic [7:0] got [0:21];
   int nFwd = 0;
   initial begin
      loadStart = 1'b0;
      inValid = 1'b0;
      inData = 8'h00;
      fwdReady = 1'b1;
   end
   // Transmit sink stalls every other cycle when slow
   always @(posedge sys_clk) begin
      fwdReady <= slow ? ~fwdReady : 1'b1;
      if (fwdValid && fwdReady) begin
         got[fwdIndex] <= fwdData;
         nFwd <= nFwd + 1;
      end
   end
   // Streams the leading n image bytes in index order
   task automatic send(input int n);
      loadStart <= 1'b1;
      @(posedge sys_clk);
      loadStart <= 1'b0;
      for (int k = 0; k < n; k++) begin
         inValid <= 1'b1;
         inData <= img[k];
         @(negedge sys_clk);
         while (inReady !== 1'b1) @(negedge sys_clk);
         @(posedge sys_clk);
      end
      inValid <= 1'b0;
      inData <= ~img[n-1];
   endtask : send
endmodule : mcbl_host
`default_nettype wire

// file: verification/mcbl_loader_test.sv
`default_nettype none
module mcbl_loader_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, reset, slow, loadStart, inValid, inReady, fwdValid;
   logic fwdReady, busy, loadDone, regWr, regRd;
   logic [7:0] inData, fwdData, regWrData, regRdData, rxThrBytes;
   logic [4:0] fwdIndex, txThrBytes;
   logic [3:0] regAddr;
   logic [2:0] txThrDwords;
   logic [5:0] rxThrDwords;
   logic [63:0] cuConfig, expCfg;
   int error_cnt = 0;
   int n_tests = 0;
   mcbl_loader dut (.sys_clk, .reset, .loadStart, .inValid, .inData,
      .inReady, .fwdValid, .fwdData, .fwdIndex, .fwdReady, .busy, .loadDone,
      .cuConfig, .txThrDwords, .txThrBytes, .rxThrDwords, .rxThrBytes,
      .regAddr, .regWrData, .regWr, .regRd, .regRdData);
   mcbl_host host (.sys_clk, .slow, .inReady, .fwdValid, .fwdData,
      .fwdIndex, .loadStart, .inValid, .inData, .fwdReady);
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : summarize
   task automatic waitDone();
      int i;
      i = 0;
      do begin
         @(negedge sys_clk);
         i++;
      end while (loadDone !== 1'b1 && i < 200);
      chk(loadDone, 1'b1);
      chk(busy, 1'b0);
      @(posedge sys_clk);
   endtask : waitDone
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRd <= 1'b0;
      @(negedge sys_clk);
      chk(regRdData, exp);
      @(posedge sys_clk);
   endtask : rd
   task automatic testReset();
      @(negedge sys_clk);
      chk(cuConfig, 64'h0800);
      chk(txThrBytes, 64'h0);
      chk(rxThrBytes, 64'h20);
      @(posedge sys_clk);
   endtask : testReset
   // Every code of both thresholds, shallow then deep receive FIFO
   task automatic testThr();
      for (int v = 0; v < 16; v++) begin
         host.img[0] = 8'h02;
         host.img[1] = 8'(v % 8 * 16 + v);
         host.send(2);
         waitDone();
         chk(txThrDwords, 64'(v % 8));
         chk(txThrBytes, 64'(v % 8 * 4));
         chk(rxThrDwords, 64'(16 - v));
         chk(rxThrBytes, 64'(64 - 4 * v));
         wr(4'h8, 8'h01);
         @(negedge sys_clk);
         chk(rxThrDwords, 64'(32 - 2 * v));
         chk(rxThrBytes, 64'(128 - 8 * v));
         @(posedge sys_clk);
         wr(4'h8, 8'h00);
      end
   endtask : testThr
   // Oversized count with a stalling sink, then register readback
   task automatic testFull();
      slow <= 1'b1;
      for (int k = 0; k < 22; k++) host.img[k] = 8'(k * 37 + 1);
      host.img[0] = 8'h3f;
      host.img[1] = 8'h08;
      for (int k = 0; k < 8; k++) expCfg[8*k +: 8] = host.img[k];
      host.send(22);
      waitDone();
      slow <= 1'b0;
      chk(host.nFwd, 64'd14);
      for (int k = 8; k < 22; k++) chk(host.got[k], host.img[k]);
      chk(cuConfig, expCfg);
      for (int k = 0; k < 8; k++) rd(4'(k), expCfg[8*k +: 8]);
      rd(4'hc, 8'h00);
   endtask : testFull
   // Eight-byte load with fixed bits set, then a one-byte load that keeps the trailing bytes
   task automatic testShort();
      host.img[0] = 8'hc8;
      host.img[1] = 8'h88;
      host.send(8);
      waitDone();
      chk(cuConfig[15:0], 16'h0808);
      chk(cuConfig[63:16], expCfg[63:16]);
      chk(host.nFwd, 64'd14);
      host.img[0] = 8'h01;
      host.send(1);
      waitDone();
      chk(cuConfig[7:0], 8'h01);
      chk(cuConfig[63:8], expCfg[63:8]);
   endtask : testShort
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (3000) @(posedge sys_clk);
      error_cnt++;
      summarize();
   end
   initial begin
      reset = 1'b1;
      slow = 1'b0;
      regAddr = 4'h0;
      regWrData = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      repeat (6) @(posedge sys_clk);
      reset <= 1'b0;
      testReset();
      testThr();
      testFull();
      testShort();
      summarize();
   end
endmodule : mcbl_loader_test
`default_nettype wire
